// >>> hw/pwr_map.svh
`ifndef PWR_MAP_SVH
`define PWR_MAP_SVH

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define IDX_P1_WAKE 8'hC0
`define IDX_OSC_MODE 8'hCA
`define IDX_PWR_STATUS 8'hCC

// ****************************************
// mode control field positions
// ****************************************
`define OSC_IDLE_BIT 4
`define OSC_SLEEP_BIT 3
`define OSC_SLOW_BIT 2
`define OSC_HSTOP_BIT 1
`define OSC_ONE_BIT 0

// ****************************************
// operating mode field codes
// ****************************************
`define MODE_NORMAL 2'h0
`define MODE_SLEEP 2'h1
`define MODE_GREEN 2'h2
`define MODE_RSVD 2'h3

// ****************************************
// reset values and warm-up counts
// ****************************************
`define OSC_MODE_RST 8'h01
`define P1_WAKE_RST 4'h0
`define WARM_XTAL_CYC 2048
`define WARM_RC_CYC 32

`endif

// >>> hw/pwr_pkg.sv
package pwr_pkg;
   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WARM, ST_GREEN} pwr_state_t;
   typedef logic [1:0] op_mode_t;
endpackage

// >>> hw/wake_if.sv
`timescale 1ns/10ps
interface wake_if #(parameter int W = 5);
   logic arm;
   logic [W-1:0] enable;
   logic change;
   modport detect (input arm, input enable, output change);
   modport ctrl (output arm, output enable, input change);
endinterface

// >>> hw/pin_wake_detect.sv
`timescale 1ns/10ps
module pin_wake_detect #(
   parameter int W = 5
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] pin,
   wake_if.detect wif
);
   logic [W-1:0] meta_r;
   logic [W-1:0] lvl_r;
   logic [W-1:0] snap_r;
   logic [W-1:0] raw_diff;
   logic chg_meta_r;
   logic chg_r;
   wire raw_any;

   generate
      for (genvar i = 0; i < W; i++)
      begin : g_pin
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_r[i] <= 1'b0;
               lvl_r[i] <= 1'b0;
               snap_r[i] <= 1'b0;
            end
            else
            begin
               meta_r[i] <= pin[i];
               lvl_r[i] <= meta_r[i];
               // snapshot freezes once armed, so the compare needs no clock
               if (!wif.arm)
                  snap_r[i] <= lvl_r[i];
            end
         end
         // either edge counts as a change
         assign raw_diff[i] = (pin[i] ^ snap_r[i]) & wif.enable[i];
      end
   endgenerate

   assign raw_any = wif.arm & (|raw_diff);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chg_meta_r <= 1'b0;
         chg_r <= 1'b0;
      end
      else
      begin
         chg_meta_r <= raw_any;
         chg_r <= chg_meta_r;
      end
   end

   assign wif.change = chg_r;
endmodule // pin_wake_detect

// >>> hw/power_mode_wakeup_ctrl.sv
`timescale 1ns/10ps
`include "pwr_map.svh"
// How it works
// - writing one to sleep_request_bit enters power-down and halts the core
// - leaving power-down clears sleep_request_bit automatically
// - power-down stops external high, internal high and internal low oscillators
// - power-down always wakes into normal high-speed mode
// - only enabled port pin changes wake power-down, never a timer overflow
// - any rising or falling edge on a wake-enabled pin is a trigger
// - port zero pins are always wake-enabled
// - port1_wake_enable: four write-only per-pin enables, cleared at reset
// - writing one to idle_request_bit enters green mode and halts the core
// - leaving green mode clears idle_request_bit automatically
// - in green mode the system clock oscillator keeps running for the timer
// - green mode wakes on port pin change or base_timer overflow
// - green mode returns to the mode used before, normal or slow
// - pwm_timer keeps running in green mode but its overflow never wakes
// - crystal high oscillator: wait 2048 high clocks after power-down wake
// - internal RC high oscillator: wait 32 high clocks after power-down wake
// - green mode wake inserts no warm-up delay
// - stopping the high oscillator in normal mode acts as power-down
// - mode field bits four to three: 00 normal, 01 sleep, 10 green
// - high_osc_stop bit one halts high oscillator; low oscillator keeps running in every mode except power-down
module power_mode_wakeup_ctrl #(
   parameter int P0_PINS = 1,
   parameter int P1_PINS = 4,
   parameter int WARM_XTAL = `WARM_XTAL_CYC,
   parameter int WARM_RC = `WARM_RC_CYC
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [P0_PINS-1:0] port_zero_pin,
   input wire logic [P1_PINS-1:0] port_one_pin,
   input wire logic base_timer_overflow,
   input wire logic pwm_timer_overflow,
   input wire logic hosc_is_rc,
   output logic cpu_run,
   output logic hosc_enable,
   output logic losc_enable,
   output logic slow_clock_sel,
   output logic base_timer_clk_en,
   output logic pwm_timer_clk_en,
   output logic [1:0] op_mode
);
   localparam int NPIN = P0_PINS + P1_PINS;
   localparam int CW = $clog2(WARM_XTAL + 1);

   // ****************************************
   // elaboration checks
   // ****************************************
   generate
      if (P1_PINS < 1 || P1_PINS > 4)
      begin : g_bad_p1
         $error("port one wake width must be 1 to 4");
      end
      if (P0_PINS < 1 || P0_PINS > 8)
      begin : g_bad_p0
         $error("port zero wake width must be 1 to 8");
      end
      if (WARM_RC < 1 || WARM_XTAL < WARM_RC)
      begin : g_bad_warm
         $error("warm-up counts must be positive, crystal not below RC");
      end
   endgenerate

   // ****************************************
   // state and registers
   // ****************************************
   pwr_pkg::pwr_state_t state_r, state_nxt;
   logic [CW-1:0] warm_cnt_r, warm_cnt_nxt;
   logic sleep_req_r, sleep_req_nxt;
   logic idle_req_r, idle_req_nxt;
   logic slow_sel_r, slow_sel_nxt;
   logic hstop_r, hstop_nxt;
   logic [P1_PINS-1:0] p1_wake_en_r, p1_wake_en_nxt;
   logic [31:0] prdata_r;
   logic cpu_run_r;
   logic hosc_en_r;
   logic losc_en_r;
   logic tmr_en_r;
   logic [1:0] op_mode_r;
   logic [1:0] op_mode_nxt;

   wake_if #(.W(NPIN)) wif ();

   // ****************************************
   // apb decode
   // ****************************************
   wire setup_ph = psel & ~penable;
   wire access_ph = psel & penable;
   wire word_ok = (paddr[1:0] == 2'h0);
   wire hit_p1 = word_ok & (paddr[9:2] == `IDX_P1_WAKE);
   wire hit_osc = word_ok & (paddr[9:2] == `IDX_OSC_MODE);
   wire hit_stat = word_ok & (paddr[9:2] == `IDX_PWR_STATUS);
   wire mapped = hit_p1 | hit_osc | hit_stat;
   wire wr_p1 = access_ph & pwrite & hit_p1;
   wire wr_osc = access_ph & pwrite & hit_osc;
   wire warm_busy = (state_r == pwr_pkg::ST_WARM);

   // zero wait states; unmapped or misaligned words answer with an error
   assign pready = 1'b1;
   assign pslverr = access_ph & ~mapped;

   // ****************************************
   // read values
   // ****************************************
   wire [7:0] osc_rd = {3'h0, idle_req_r, sleep_req_r, slow_sel_r, hstop_r, 1'b1};
   // enables are write-only, so that word reads back as zero
   wire [7:0] stat_rd = {5'h0, warm_busy, op_mode_r};
   wire [7:0] rd_sel = hit_osc ? osc_rd : (hit_stat ? stat_rd : 8'h00);

   // ****************************************
   // mode field and entry conditions
   // ****************************************
   wire [1:0] mode_field = {idle_req_r, sleep_req_r};
   // reserved code 11 requests nothing
   wire want_sleep = (mode_field == `MODE_SLEEP);
   wire want_green = (mode_field == `MODE_GREEN);
   // normal mode with its high oscillator stopped has no clock left
   wire no_sys_clk = hstop_r & ~slow_sel_r;
   wire pin_wake = wif.change;
   // pwm_timer_overflow is deliberately not a wake source
   wire green_wake = pin_wake | base_timer_overflow;
   wire [CW-1:0] warm_load = hosc_is_rc ? CW'(WARM_RC) : CW'(WARM_XTAL);

   // ****************************************
   // wake detector
   // ****************************************
   // port zero pins always armed, port one pins per enable bit
   assign wif.enable = {p1_wake_en_r, {P0_PINS{1'b1}}};
   assign wif.arm = (state_r == pwr_pkg::ST_SLEEP) | (state_r == pwr_pkg::ST_GREEN);

   pin_wake_detect #(
      .W(NPIN)
   ) u_detect (
      .clk(pclk),
      .rst_n(presetn),
      .pin({port_one_pin, port_zero_pin}),
      .wif(wif.detect)
   );

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb
   begin
      state_nxt = state_r;
      warm_cnt_nxt = warm_cnt_r;
      sleep_req_nxt = sleep_req_r;
      idle_req_nxt = idle_req_r;
      slow_sel_nxt = slow_sel_r;
      hstop_nxt = hstop_r;
      p1_wake_en_nxt = p1_wake_en_r;
      case (state_r)
         pwr_pkg::ST_RUN:
         begin
            if (want_sleep || no_sys_clk)
            begin
               state_nxt = pwr_pkg::ST_SLEEP;
            end
            else if (want_green)
            begin
               state_nxt = pwr_pkg::ST_GREEN;
            end
         end
         pwr_pkg::ST_SLEEP:
         begin
            // a timer overflow cannot reach this branch
            if (pin_wake)
            begin
               state_nxt = pwr_pkg::ST_WARM;
               warm_cnt_nxt = warm_load;
               sleep_req_nxt = 1'b0;
               slow_sel_nxt = 1'b0;
               hstop_nxt = 1'b0;
            end
         end
         pwr_pkg::ST_WARM:
         begin
            if (warm_cnt_r <= CW'(1))
            begin
               state_nxt = pwr_pkg::ST_RUN;
               warm_cnt_nxt = '0;
            end
            else
            begin
               warm_cnt_nxt = warm_cnt_r - CW'(1);
            end
         end
         pwr_pkg::ST_GREEN:
         begin
            if (green_wake)
            begin
               // straight back to run, slow select untouched
               state_nxt = pwr_pkg::ST_RUN;
               idle_req_nxt = 1'b0;
            end
         end
         default:
         begin
            state_nxt = pwr_pkg::ST_RUN;
         end
      endcase
      // a software write lands after the hardware clear, so it is never lost
      if (wr_osc)
      begin
         idle_req_nxt = pwdata[`OSC_IDLE_BIT];
         sleep_req_nxt = pwdata[`OSC_SLEEP_BIT];
         slow_sel_nxt = pwdata[`OSC_SLOW_BIT];
         hstop_nxt = pwdata[`OSC_HSTOP_BIT];
      end
      if (wr_p1)
      begin
         p1_wake_en_nxt = pwdata[P1_PINS-1:0];
      end
   end

   // ****************************************
   // output decode
   // ****************************************
   always_comb
   begin
      case (state_nxt)
         pwr_pkg::ST_SLEEP: op_mode_nxt = `MODE_SLEEP;
         pwr_pkg::ST_WARM: op_mode_nxt = `MODE_SLEEP;
         pwr_pkg::ST_GREEN: op_mode_nxt = `MODE_GREEN;
         default: op_mode_nxt = `MODE_NORMAL;
      endcase
   end

   wire run_nxt = (state_nxt == pwr_pkg::ST_RUN);
   wire sleep_nxt = (state_nxt == pwr_pkg::ST_SLEEP);
   wire warm_nxt = (state_nxt == pwr_pkg::ST_WARM);
   // every oscillator stops in power-down; warm-up forces the high one on
   wire hosc_nxt = warm_nxt | (~sleep_nxt & ~hstop_nxt);
   wire losc_nxt = ~sleep_nxt;
   // both timers keep their clock in green mode
   wire tmr_nxt = ~sleep_nxt & ~warm_nxt;

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= pwr_pkg::ST_RUN;
         warm_cnt_r <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         warm_cnt_r <= warm_cnt_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         idle_req_r <= 1'b0;
         sleep_req_r <= 1'b0;
         slow_sel_r <= 1'b0;
         hstop_r <= 1'b0;
      end
      else
      begin
         idle_req_r <= idle_req_nxt;
         sleep_req_r <= sleep_req_nxt;
         slow_sel_r <= slow_sel_nxt;
         hstop_r <= hstop_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         p1_wake_en_r <= P1_PINS'(`P1_WAKE_RST);
      else
         p1_wake_en_r <= p1_wake_en_nxt;
   end

   // read data is captured in the setup phase and stands through access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_r <= 32'h0000_0000;
      else if (setup_ph && !pwrite)
         prdata_r <= {24'h00_0000, rd_sel};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cpu_run_r <= 1'b1;
         hosc_en_r <= 1'b1;
         losc_en_r <= 1'b1;
         tmr_en_r <= 1'b1;
         op_mode_r <= `MODE_NORMAL;
      end
      else
      begin
         cpu_run_r <= run_nxt;
         hosc_en_r <= hosc_nxt;
         losc_en_r <= losc_nxt;
         tmr_en_r <= tmr_nxt;
         op_mode_r <= op_mode_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign prdata = prdata_r;
   assign cpu_run = cpu_run_r;
   assign hosc_enable = hosc_en_r;
   assign losc_enable = losc_en_r;
   assign slow_clock_sel = slow_sel_r;
   assign base_timer_clk_en = tmr_en_r;
   assign pwm_timer_clk_en = tmr_en_r;
   assign op_mode = op_mode_r;

endmodule // power_mode_wakeup_ctrl

// >>> tb/pwr_mode_checker.sv
`timescale 1ns/10ps
module pwr_mode_checker #(
   parameter int WARM_XTAL = 2048,
   parameter int WARM_RC = 32
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic base_timer_overflow,
   input wire logic hosc_is_rc,
   input wire logic cpu_run,
   input wire logic hosc_enable,
   input wire logic losc_enable,
   input wire logic slow_clock_sel,
   input wire logic base_timer_clk_en,
   input wire logic pwm_timer_clk_en,
   input wire logic [1:0] op_mode
);
   int warm_cnt;
   int warm_lim;
   wire osc_wr = psel && penable && pwrite && paddr == 10'h328;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign warm_lim = hosc_is_rc ? WARM_RC : WARM_XTAL;
   // ****
   // warm-up length, counted while halted with the high oscillator back on
   // ****
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         warm_cnt <= 0;
      else if (cpu_run)
         warm_cnt <= 0;
      else if (hosc_enable && op_mode == 2'h1)
         warm_cnt <= warm_cnt + 1;
   sequence sleep_req;
      osc_wr && cpu_run && (pwdata[4:3] == 2'h1 || pwdata[4:1] == 4'h1);
   endsequence
   sequence green_req;
      osc_wr && cpu_run && pwdata[4:3] == 2'h2;
   endsequence
   sequence woke_from(logic [1:0] m);
      $rose(cpu_run) && $past(op_mode) == m;
   endsequence
   a_sleep_entry: assert property (sleep_req |-> ##[1:2]
      (!cpu_run && op_mode == 2'h1 && !hosc_enable && !losc_enable && !base_timer_clk_en &&
      !pwm_timer_clk_en)) else $error("bad sleep");
   a_green_entry: assert property (green_req |-> ##[1:2]
      (!cpu_run && op_mode == 2'h2 && pwm_timer_clk_en)) else $error("bad green entry");
   a_green_clock: assert property (op_mode == 2'h2 |->
      (slow_clock_sel ? losc_enable : hosc_enable) && base_timer_clk_en) else $error("clock off");
   a_timer_wakes_green: assert property (op_mode == 2'h2 && !cpu_run &&
      base_timer_overflow |=> cpu_run) else $error("timer did not wake");
   a_sleep_no_timer: assert property (op_mode == 2'h1 && !hosc_enable &&
      base_timer_overflow |=> !hosc_enable) else $error("timer woke sleep");
   a_warm_count: assert property (woke_from(2'h1) |-> op_mode == 2'h0 &&
      !slow_clock_sel && warm_cnt >= warm_lim && warm_cnt <= warm_lim + 1) else $error("warm");
   a_green_return: assert property (woke_from(2'h2) |-> op_mode == 2'h0 &&
      slow_clock_sel == $past(slow_clock_sel)) else $error("bad return mode");
   a_reserved_noop: assert property (osc_wr && cpu_run && pwdata[4:3] == 2'h3 &&
      !pwdata[1] |=> cpu_run [*3]) else $error("reserved code halted");
endmodule // pwr_mode_checker
bind power_mode_wakeup_ctrl pwr_mode_checker #(.WARM_XTAL(WARM_XTAL), .WARM_RC(WARM_RC)) u_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .base_timer_overflow,
   .hosc_is_rc, .cpu_run, .hosc_enable, .losc_enable, .slow_clock_sel, .base_timer_clk_en,
   .pwm_timer_clk_en, .op_mode);

// >>> tb/wake_partner.sv
`timescale 1ns/10ps
module wake_partner #(
   parameter int PERIOD = 6
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tmr_on,
   input wire logic kick,
   input wire logic [4:0] flip,
   input wire logic base_timer_clk_en,
   input wire logic pwm_timer_clk_en,
   output logic [0:0] port_zero_pin,
   output logic [3:0] port_one_pin,
   output logic base_timer_overflow,
   output logic pwm_timer_overflow
);
   int cnt;
   // ****
   // pins with pull-ups, base timer and pwm timer
   // ****
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         {port_one_pin, port_zero_pin} <= 5'h1F;
         cnt <= 0;
         base_timer_overflow <= 1'b0;
         pwm_timer_overflow <= 1'b0;
      end
      else
      begin
         {port_one_pin, port_zero_pin} <= {port_one_pin, port_zero_pin} ^ flip;
         // counts only on a running clock; kick is a forced fault for the sleep case
         if (base_timer_clk_en && tmr_on)
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         base_timer_overflow <= kick || (base_timer_clk_en && tmr_on && cnt == PERIOD - 1);
         pwm_timer_overflow <= pwm_timer_clk_en && !pwm_timer_overflow;
      end
endmodule // wake_partner

// >>> tb/tb.sv
`timescale 1ns/10ps
`define CHK(g, w) begin tests_run++; if ((g) !== (w)) begin fail_count++; \
   $display("unexpected at %0t: got %0h want %0h", $time, g, w); end end
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [9:0] paddr = 10'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, hosc_is_rc = 1'b0, tmr_on = 1'b0, kick = 1'b0;
   logic [4:0] flip = 5'h0;
   logic [0:0] port_zero_pin;
   logic [3:0] port_one_pin;
   logic base_timer_overflow, pwm_timer_overflow, cpu_run, hosc_enable, losc_enable;
   logic slow_clock_sel, base_timer_clk_en, pwm_timer_clk_en;
   logic [1:0] op_mode;
   int fail_count = 0, tests_run = 0, cycles = 0;
   always #4 pclk = ~pclk;
   power_mode_wakeup_ctrl #(.WARM_XTAL(8), .WARM_RC(2)) dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .port_zero_pin, .port_one_pin,
      .base_timer_overflow, .pwm_timer_overflow, .hosc_is_rc, .cpu_run, .hosc_enable,
      .losc_enable, .slow_clock_sel, .base_timer_clk_en, .pwm_timer_clk_en, .op_mode);
   wake_partner partner (.pclk, .presetn, .tmr_on, .kick, .flip, .base_timer_clk_en,
      .pwm_timer_clk_en, .port_zero_pin, .port_one_pin, .base_timer_overflow,
      .pwm_timer_overflow);
   // ****
   // tasks
   // ****
   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // only the bench timeout ends a wait
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rchk(input logic [9:0] a, input logic [31:0] x, input logic e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, x)
      `CHK(err, e)
      `CHK(pready, 1'b1)
   endtask
   // samples on the falling edge so registered outputs have settled
   task automatic wait_run(input logic v);
      repeat (60)
         if (cpu_run !== v)
            @(negedge pclk);
      `CHK(cpu_run, v)
   endtask
   task automatic mode_run(input logic [7:0] pre, w, input logic rc, input logic [1:0] om, osc,
         input logic [4:0] wk, input logic [7:0] back);
      hosc_is_rc <= rc;
      apb(1'b1, 10'h328, {24'h0, pre});
      apb(1'b1, 10'h328, {24'h0, w});
      wait_run(1'b0);
      `CHK(op_mode, om)
      `CHK({hosc_enable, losc_enable}, osc)
      @(posedge pclk);
      flip <= 5'h10;
      kick <= (om == 2'h1);
      @(posedge pclk);
      flip <= 5'h0;
      kick <= 1'b0;
      repeat (20) @(negedge pclk);
      `CHK(cpu_run, 1'b0)
      @(posedge pclk);
      tmr_on <= (wk == 5'h0);
      flip <= wk;
      @(posedge pclk);
      flip <= 5'h0;
      wait_run(1'b1);
      `CHK(op_mode, 2'h0)
      @(posedge pclk);
      tmr_on <= 1'b0;
      apb(1'b0, 10'h328, 32'h0);
      `CHK(rd, {24'h0, back})
   endtask
   // ****
   // sequence and hang guard
   // ****
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         fail_count++;
         print_verdict;
      end
   end
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(cpu_run, 1'b1)
      rchk(10'h328, 32'h1, 1'b0);
      rchk(10'h330, 32'h0, 1'b0);
      apb(1'b1, 10'h300, 32'hF);
      rchk(10'h300, 32'h0, 1'b0);
      rchk(10'h3FC, 32'h0, 1'b1);
      rchk(10'h329, 32'h0, 1'b1);
      apb(1'b1, 10'h300, 32'h2);
      mode_run(8'h01, 8'h11, 1'b0, 2'h2, 2'h3, 5'h00, 8'h01);
      mode_run(8'h05, 8'h15, 1'b0, 2'h2, 2'h3, 5'h01, 8'h05);
      mode_run(8'h01, 8'h09, 1'b0, 2'h1, 2'h0, 5'h04, 8'h01);
      mode_run(8'h05, 8'h0D, 1'b1, 2'h1, 2'h0, 5'h01, 8'h01);
      mode_run(8'h01, 8'h03, 1'b1, 2'h1, 2'h0, 5'h04, 8'h01);
      apb(1'b1, 10'h328, 32'h19);
      repeat (10) @(negedge pclk);
      `CHK(cpu_run, 1'b1)
      @(posedge pclk);
      print_verdict;
   end
endmodule // tb
